// ### hw/asr_host.sv
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
module asr_host (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       clk_en,
  input  wire logic [asr_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [asr_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  asr_if.host                             lnk
);
  import asr_pkg::*;

  typedef struct packed {
    logic [HS_W-1:0]           s1, s2, s3, flt;
    logic                      aw_got, w_got, awready, wready, bvalid;
    logic                      arready, rvalid;
    logic [ADDR_W-1:0]         awa;
    logic [31:0]               wd, rdata;
    logic [3:0]                ws;
    logic [1:0]                bresp, rresp;
    logic                      lvds, pd, done, strt, cs_n, sck;
    logic [CFG_W-1:0]          cfg, tx;
    asr_hst_t                  st;
    logic [7:0]                div, tog, strt_n;
    logic [FRAME_W-1:0]        rx;
    logic [NCH-1:0][WORD_W-1:0] data;
    logic                      ck_c, ck_l, di_c, di_l;
  } asr_host_st_t;

  asr_host_st_t q;
  asr_host_st_t d;
  logic [HS_W-1:0] fl;
  logic [31:0]     rd;
  logic            rok;
  logic            wok;
  logic [31:0]     mrg;
  logic [7:0]      tot;

  always_comb begin
    d = q;
    rd = '0;
    rok = 1'b0;
    wok = 1'b0;
    fl = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.flt);
    d.s1 = {lnk.diff_data_line, lnk.busy, lnk.lane_line};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.flt = fl;
    for (int b = 0; b < 4; b++) begin
      mrg[b*8 +: 8] = q.ws[b] ? q.wd[b*8 +: 8]
                              : 8'({8'h00, q.cfg} >> (b*8));
    end
    if (araddr == REG_CTRL) begin
      rok = 1'b1;
      rd[CTRL_PD] = q.pd;
      rd[CTRL_LVDS] = q.lvds;
    end else if (araddr == REG_CFG) begin
      rok = 1'b1;
      rd[CFG_W-1:0] = q.cfg;
    end else if (araddr == REG_STAT) begin
      rok = 1'b1;
      rd[STAT_BUSY] = fl[HS_BUSY];
      rd[STAT_ACT] = q.st != H_IDLE;
      rd[STAT_DONE] = q.done;
    end
    for (int i = 0; i < NCH; i++) begin
      if (araddr == REG_DATA0 + ADDR_W'(i * REG_STRIDE)) begin
        rok = 1'b1;
        rd[WORD_W-1:0] = q.data[i];
      end
      if (q.awa == REG_DATA0 + ADDR_W'(i * REG_STRIDE)) begin
        wok = 1'b1;
      end
    end
    if (q.strt_n != '0) begin
      d.strt_n = q.strt_n - 8'h01;
    end else begin
      d.strt = 1'b0;
    end
    if (awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.awa = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wd = wdata;
      d.ws = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (q.awa == REG_CTRL) begin
        if (q.ws[0]) begin
          d.pd = q.wd[CTRL_PD];
          d.lvds = q.wd[CTRL_LVDS];
          if (q.wd[CTRL_CONV]) begin
            d.strt = 1'b1;
            d.strt_n = 8'(HALF_CYC);
          end
          if (q.wd[CTRL_XFER] && q.st == H_IDLE) begin
            d.st = H_LEAD;
            d.cs_n = 1'b0;
            d.tx = q.cfg;
            d.div = '0;
            d.tog = '0;
            d.done = 1'b0;
          end
        end
      end else if (q.awa == REG_CFG) begin
        d.cfg = mrg[CFG_W-1:0];
      end else if (q.awa != REG_STAT && !wok) begin
        d.bresp = RESP_SLVERR;
      end
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd;
      d.rresp = rok ? RESP_OKAY : RESP_SLVERR;
    end
    tot = q.lvds ? 8'(LVDS_TOG) : 8'(CMOS_TOG);
    unique case (q.st)
      H_IDLE: begin
        // a start in this cycle keeps the word just loaded
        if (d.st == H_IDLE) begin
          d.tx = '1;
        end
      end
      H_LEAD, H_TAIL: begin
        d.div = q.div + 8'h01;
        if (q.div == 8'(HALF_CYC - 1)) begin
          d.div = '0;
          if (q.st == H_LEAD) begin
            d.st = H_RUN;
          end else begin
            d.st = H_IDLE;
            d.cs_n = 1'b1;
            d.done = 1'b1;
            for (int i = 0; i < NCH; i++) begin
              d.data[i] = q.lvds ? q.rx[(NCH-1-i)*WORD_W +: WORD_W]
                                 : q.rx[i*WORD_W +: WORD_W];
            end
          end
        end
      end
      H_RUN: begin
        d.div = q.div + 8'h01;
        if (q.div == 8'(HALF_CYC - 1)) begin
          d.div = '0;
          if (q.lvds) begin
            d.rx = {q.rx[FRAME_W-2:0], fl[HS_DIFF]};
          end else if (!q.sck) begin
            for (int k = 0; k < NCH; k++) begin
              d.rx[k*WORD_W +: WORD_W] =
                {q.rx[k*WORD_W +: WORD_W-1], fl[k]};
            end
          end
          d.sck = !q.sck;
          d.tog = q.tog + 8'h01;
          if (q.tog == tot - 8'h01) begin
            d.st = H_TAIL;
          end
        end else if (q.div == 8'(HALF_CYC / 2 - 1) && q.tog != '0
                     && (q.lvds || q.sck)) begin
          d.tx = {q.tx[CFG_W-2:0], 1'b1};
        end
      end
    endcase
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;
    d.arready = !d.rvalid;
    d.ck_c = d.sck && !d.lvds;
    d.ck_l = d.sck && d.lvds;
    d.di_c = d.tx[CFG_W-1];
    d.di_l = d.tx[CFG_W-1] && d.lvds;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.cs_n <= 1'b1;
      q.cfg <= CFG_RST;
      q.tx <= '1;
      q.di_c <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bresp = q.bresp;
  assign bvalid = q.bvalid;
  assign arready = q.arready;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign rvalid = q.rvalid;
  assign lnk.cs_n = q.cs_n;
  assign lnk.shift_clock_in = q.ck_c;
  assign lnk.diff_shift_clock_in = q.ck_l;
  assign lnk.config_serial_in = q.di_c;
  assign lnk.diff_config_in = q.di_l;
  assign lnk.convert_start = q.strt;
  assign lnk.power_down_in = q.pd;
  assign lnk.io_mode_lvds = q.lvds;
endmodule // asr_host

// ### hw/asr_pkg.sv
package asr_pkg;
  localparam int NCH       = 8;
  localparam int CODE_W    = 3;
  localparam int RES_W     = 16;
  localparam int WORD_W    = 24;
  localparam int PAD_W     = WORD_W - RES_W - 2 * CODE_W;
  localparam int CFG_W     = NCH * CODE_W;
  localparam int FRAME_W   = NCH * WORD_W;
  localparam int BIP_BIT   = 1;
  localparam logic [CFG_W-1:0]  CFG_RST  = 24'hffffff;
  localparam logic [CODE_W-1:0] CODE_OFF = 3'h0;
  // device pin synchroniser bit positions
  localparam int SY_CS     = 0;
  localparam int SY_SCK    = 1;
  localparam int SY_CFGI   = 2;
  localparam int SY_DSCK   = 3;
  localparam int SY_DCFG   = 4;
  localparam int SY_STRT   = 5;
  localparam int SY_PD     = 6;
  localparam int SY_MODE   = 7;
  localparam int SYNC_W    = 8;
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'h01;
  // host synchroniser: lanes, then busy, then lvds data
  localparam int HS_BUSY   = NCH;
  localparam int HS_DIFF   = NCH + 1;
  localparam int HS_W      = NCH + 2;
  // timing
  localparam int CLK_NS    = 50;
  localparam int LINK_NS   = 1600;
  localparam int HALF_CYC  = LINK_NS / (2 * CLK_NS);
  localparam int CONV_CYC_DEF = 32;
  localparam int CMOS_TOG  = 2 * WORD_W;
  localparam int LVDS_TOG  = FRAME_W;
  // host register map
  localparam int ADDR_W    = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CFG   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STAT  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_DATA0 = 8'h20;
  localparam int REG_STRIDE = 4;
  localparam int CTRL_CONV = 0;
  localparam int CTRL_XFER = 1;
  localparam int CTRL_PD   = 2;
  localparam int CTRL_LVDS = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACT  = 1;
  localparam int STAT_DONE = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LEAD = 2'b01,
    H_RUN  = 2'b11,
    H_TAIL = 2'b10
  } asr_hst_t;
endpackage

// ### hw/asr_if.sv
`timescale 1ns/1ns
interface asr_if;
  logic       cs_n;
  logic       shift_clock_in;
  logic       diff_shift_clock_in;
  logic       config_serial_in;
  logic       diff_config_in;
  logic       convert_start;
  logic       power_down_in;
  logic       io_mode_lvds;
  logic [7:0] lane_data_out;
  logic [7:0] lane_oe_n;
  logic       echo_clock_out;
  logic       echo_oe_n;
  logic       diff_data_out;
  logic       diff_echo_clock_out;
  logic       diff_oe_n;
  logic       term_en;
  logic       busy;
  wire  [7:0] lane_line;
  wire        diff_data_line;
  genvar i;
  for (i = 0; i < 8; i++) begin : g_lane
    assign lane_line[i] = lane_oe_n[i] ? ~lane_data_out[i] : lane_data_out[i];
  end
  assign diff_data_line = diff_oe_n ? ~diff_data_out : diff_data_out;
  modport dev (
    input  cs_n, shift_clock_in, diff_shift_clock_in, config_serial_in,
    input  diff_config_in, convert_start, power_down_in, io_mode_lvds,
    output lane_data_out, lane_oe_n, echo_clock_out, echo_oe_n,
    output diff_data_out, diff_echo_clock_out, diff_oe_n, term_en, busy
  );
  modport host (
    output cs_n, shift_clock_in, diff_shift_clock_in, config_serial_in,
    output diff_config_in, convert_start, power_down_in, io_mode_lvds,
    input  lane_line, diff_data_line, busy
  );
endinterface

// ### hw/asr_dev.sv
`timescale 1ns/1ns
module asr_dev #(
  parameter int CONV_CYC = asr_pkg::CONV_CYC_DEF
) (
  input  wire logic                                    aclk,
  input  wire logic                                    aresetn,
  input  wire logic                                    clk_en,
  input  wire logic [asr_pkg::NCH-1:0][asr_pkg::RES_W-1:0] sample_in,
  asr_if.dev                                           lnk
);
  import asr_pkg::*;

  localparam int CNT_W = $clog2(CONV_CYC + 1);
  localparam int IDX_W = $clog2(FRAME_W);
  localparam int CFN_W = $clog2(CFG_W + 1);

  typedef struct packed {
    logic [SYNC_W-1:0]             s1;
    logic [SYNC_W-1:0]             s2;
    logic [SYNC_W-1:0]             s3;
    logic [SYNC_W-1:0]             flt;
    logic                          busy;
    logic [CNT_W-1:0]              cnt;
    logic                          pd_seen;
    logic [CFG_W-1:0]              cfg_act;
    logic [CFG_W-1:0]              cfg_pend;
    logic [CFG_W-1:0]              cfg_sh;
    logic                          pend_v;
    logic [CFN_W-1:0]              cfg_n;
    logic [NCH-1:0][RES_W-1:0]     samp;
    logic [FRAME_W-1:0]            frame;
    logic [IDX_W-1:0]              idx;
    logic [NCH-1:0]                lane;
    logic [NCH-1:0]                lane_oe_n;
    logic                          echo;
    logic                          echo_oe_n;
    logic                          ddat;
    logic                          decho;
    logic                          d_oe_n;
    logic                          term;
  } asr_dev_st_t;

  asr_dev_st_t q;
  asr_dev_st_t d;

  function automatic logic [WORD_W-1:0] mk_word(
    input logic [CODE_W-1:0] chan,
    input logic [CODE_W-1:0] code,
    input logic [RES_W-1:0]  raw
  );
    logic [RES_W-1:0] res;
    res = raw;
    if (code[BIP_BIT]) begin
      res[RES_W-1] = ~raw[RES_W-1];
    end
    if (code == CODE_OFF) begin
      res = '0;
    end
    mk_word = {res, {PAD_W{1'b0}}, chan, code};
  endfunction

  logic [SYNC_W-1:0] fn;
  logic              lvds;
  logic              cs_lo;
  logic              cs_fall;
  logic              ck_n;
  logic              ck_o;
  logic              sedge;
  logic              cfg_bit;
  logic              strt_rise;
  logic              pd_rise;
  logic [CFG_W-1:0]  cfg_new;
  int                pos;

  always_comb begin
    d = q;
    pos = 0;
    // a level counts once the second and third stages agree
    fn = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.flt);
    d.s1 = {lnk.io_mode_lvds, lnk.power_down_in, lnk.convert_start,
            lnk.diff_config_in, lnk.diff_shift_clock_in,
            lnk.config_serial_in, lnk.shift_clock_in, lnk.cs_n};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.flt = fn;
    lvds = fn[SY_MODE];
    cs_lo = !fn[SY_CS];
    cs_fall = q.flt[SY_CS] && !fn[SY_CS];
    ck_n = lvds ? fn[SY_DSCK] : fn[SY_SCK];
    ck_o = lvds ? q.flt[SY_DSCK] : q.flt[SY_SCK];
    // shift clock is blocked unless chip select is low
    sedge = cs_lo && !cs_fall && (ck_n != ck_o)
            && (lvds || ck_n);
    cfg_bit = lvds ? fn[SY_DCFG] : fn[SY_CFGI];
    strt_rise = fn[SY_STRT] && !q.flt[SY_STRT];
    pd_rise = fn[SY_PD] && !q.flt[SY_PD];
    cfg_new = {q.cfg_sh[CFG_W-2:0], cfg_bit};

    // conversion engine
    if (q.busy) begin
      if (q.cnt == '0) begin
        d.busy = 1'b0;
        d.pd_seen = 1'b0;
        for (int i = 0; i < NCH; i++) begin
          d.frame[FRAME_W-1-i*WORD_W -: WORD_W] =
            mk_word(CODE_W'(i), q.cfg_act[i*CODE_W +: CODE_W],
                    q.samp[i]);
        end
      end else begin
        d.cnt = q.cnt - CNT_W'(1);
      end
    end else if (strt_rise && !fn[SY_PD]) begin
      d.busy = 1'b1;
      d.cnt = CNT_W'(CONV_CYC - 1);
      d.samp = sample_in;
      if (q.pend_v) begin
        d.cfg_act = q.cfg_pend;
        d.pend_v = 1'b0;
      end
    end

    // second power-down with no conversion in between
    if (pd_rise) begin
      if (q.pd_seen && !q.busy) begin
        d.cfg_act = CFG_RST;
        d.cfg_pend = CFG_RST;
        d.pend_v = 1'b0;
        d.cfg_n = '0;
        d.frame = '0;
        d.samp = '0;
        d.pd_seen = 1'b0;
      end else begin
        d.pd_seen = 1'b1;
      end
    end

    // configuration word, msb first; extra bits are dropped
    if (cs_fall) begin
      d.cfg_n = '0;
    end else if (sedge && q.cfg_n < CFN_W'(CFG_W)) begin
      d.cfg_sh = cfg_new;
      d.cfg_n = q.cfg_n + CFN_W'(1);
      if (q.cfg_n == CFN_W'(CFG_W - 1)) begin
        d.cfg_pend = cfg_new;
        d.pend_v = 1'b1;
      end
    end

    // output bit pointer
    if (cs_fall) begin
      d.idx = '0;
    end else if (sedge) begin
      if (q.idx == IDX_W'(FRAME_W - 1)) begin
        d.idx = '0;
      end else begin
        d.idx = q.idx + IDX_W'(1);
      end
    end

    if (sedge && !lvds) begin
      d.echo = !q.echo;
    end
    if (q.busy && !d.busy) begin
      d.echo = 1'b0;
    end

    // each lane starts at its own channel and walks on
    for (int k = 0; k < NCH; k++) begin
      pos = k * WORD_W + int'(d.idx);
      if (pos >= FRAME_W) begin
        pos = pos - FRAME_W;
      end
      d.lane[k] = d.frame[FRAME_W-1-pos];
    end
    d.ddat = d.frame[FRAME_W-1-int'(d.idx)];
    d.decho = cs_lo && lvds && fn[SY_DSCK];
    d.lane_oe_n = {NCH{!(cs_lo && !lvds)}};
    d.echo_oe_n = !(cs_lo && !lvds);
    d.d_oe_n = !(cs_lo && lvds);
    d.term = cs_lo && lvds;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.s1 <= SYNC_RST;
      q.s2 <= SYNC_RST;
      q.s3 <= SYNC_RST;
      q.flt <= SYNC_RST;
      q.cfg_act <= CFG_RST;
      q.cfg_pend <= CFG_RST;
      q.lane_oe_n <= '1;
      q.echo_oe_n <= 1'b1;
      q.d_oe_n <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign lnk.lane_data_out = q.lane;
  assign lnk.lane_oe_n = q.lane_oe_n;
  assign lnk.echo_clock_out = q.echo;
  assign lnk.echo_oe_n = q.echo_oe_n;
  assign lnk.diff_data_out = q.ddat;
  assign lnk.diff_echo_clock_out = q.decho;
  assign lnk.diff_oe_n = q.d_oe_n;
  assign lnk.term_en = q.term;
  assign lnk.busy = q.busy;
endmodule // asr_dev

// ### testbench/asr_checker.sv
`timescale 1ns/1ns
module asr_checker #(
  parameter int CONV_CYC = 32
) (
  input logic       aclk,
  input logic       aresetn,
  input logic       cs_n,
  input logic       shift_clock_in,
  input logic       diff_shift_clock_in,
  input logic       io_mode_lvds,
  input logic       convert_start,
  input logic       power_down_in,
  input logic [7:0] lane_oe_n,
  input logic       echo_clock_out,
  input logic       echo_oe_n,
  input logic       diff_echo_clock_out,
  input logic       diff_oe_n,
  input logic       term_en,
  input logic       busy
);
  int busy_cnt_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // counts consecutive busy cycles to bound the conversion length
  always_ff @(posedge aclk) begin
    if (!aresetn) busy_cnt_q <= 0;
    else busy_cnt_q <= busy ? busy_cnt_q + 1 : 0;
  end
  cs_hiz_a: assert property (cs_n [*8] |->
    &lane_oe_n && echo_oe_n && diff_oe_n)
    else $error("outputs driven while deselected");
  lvds_pins_a: assert property (io_mode_lvds [*8] |->
    lane_oe_n[0] && lane_oe_n[7])
    else $error("cmos pins driven in lvds mode");
  term_off_a: assert property (cs_n [*8] |-> !term_en)
    else $error("termination on while deselected");
  term_on_a: assert property ((!cs_n && io_mode_lvds) [*8] |->
    term_en)
    else $error("termination off while selected");
  busy_start_a: assert property ($rose(convert_start) &&
    !busy && !power_down_in |-> ##[2:8] busy)
    else $error("conversion start without busy");
  busy_len_a: assert property ($fell(busy) |->
    busy_cnt_q >= CONV_CYC - 1 && busy_cnt_q <= CONV_CYC + 1)
    else $error("busy length wrong");
  echo_low_a: assert property ($fell(busy) |->
    ##[0:1] !echo_clock_out)
    else $error("echo clock not low after busy");
  cmos_echo_a: assert property ($rose(shift_clock_in) &&
    !cs_n && !io_mode_lvds |-> ##[2:8] $changed(echo_clock_out))
    else $error("echo clock did not toggle");
  lvds_echo_a: assert property ($changed(diff_shift_clock_in) &&
    !cs_n && io_mode_lvds |->
    ##[2:8] diff_echo_clock_out == diff_shift_clock_in)
    else $error("lvds echo does not follow clock");
  clk_idle_a: assert property ($changed(cs_n) |->
    !shift_clock_in && !diff_shift_clock_in)
    else $error("shift clock high at select change");
endmodule // asr_checker

// ### testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import asr_pkg::*;
  logic                      aclk = 1'b0, aresetn = 1'b0;
  logic                      awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                      arvalid = 1'b0, rready = 1'b0;
  logic [7:0]                awaddr = 8'h0, araddr = 8'h0;
  logic [31:0]               wdata = 32'h0, rdata, rd;
  logic [3:0]                wstrb = 4'hf;
  logic                      awready, wready, bvalid, arready, rvalid;
  logic [1:0]                bresp, rresp, rs;
  logic [NCH-1:0][RES_W-1:0] sample_in = '0;
  int                        n_errors = 0, tests_run = 0;
  always #25 aclk = ~aclk;
  asr_if lnk ();
  asr_dev #(.CONV_CYC(CONV_CYC_DEF)) asr_dev_i (.aclk(aclk),
    .aresetn(aresetn), .clk_en(1'b1), .sample_in(sample_in), .lnk(lnk));
  asr_host asr_host_i (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .lnk(lnk));
  asr_checker #(.CONV_CYC(CONV_CYC_DEF)) asr_checker_i (.aclk(aclk),
    .aresetn(aresetn), .cs_n(lnk.cs_n), .shift_clock_in(lnk.shift_clock_in),
    .diff_shift_clock_in(lnk.diff_shift_clock_in),
    .io_mode_lvds(lnk.io_mode_lvds), .convert_start(lnk.convert_start),
    .power_down_in(lnk.power_down_in), .lane_oe_n(lnk.lane_oe_n),
    .echo_clock_out(lnk.echo_clock_out), .echo_oe_n(lnk.echo_oe_n),
    .diff_echo_clock_out(lnk.diff_echo_clock_out),
    .diff_oe_n(lnk.diff_oe_n), .term_en(lnk.term_en), .busy(lnk.busy));
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tmo;
    n_errors++;
    $display("[FAIL] %0t wait ran out", $time);
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 99);
    bready <= 1'b0;
    rs = bresp;
    if (n == 99) tmo();
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 99);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    if (n == 99) tmo();
  endtask
  // expected word: result, pad, channel, code
  function automatic logic [31:0] ew(input int i, input logic [2:0] c);
    logic [15:0] r;
    r = sample_in[i];
    if (c[BIP_BIT]) r[15] = ~r[15];
    if (c == CODE_OFF) r = 16'h0;
    return {8'h0, r, 2'h0, i[2:0], c};
  endfunction
  task automatic conv(input logic [31:0] m, input logic [15:0] b,
                      input logic e);
    int n;
    logic s;
    for (int i = 0; i < NCH; i++) sample_in[i] <= b + RES_W'(16'h1357 * i);
    axw(REG_CTRL, m | 32'h1);
    s = 1'b0;
    for (n = 0; n < 120 && !(s && lnk.busy === 1'b0); n++) begin
      @(posedge aclk);
      s = s | (lnk.busy === 1'b1);
    end
    chk({31'h0, s}, {31'h0, e});
    chk({31'h0, lnk.busy}, 32'h0);
  endtask
  task automatic xfer(input logic [31:0] m, input logic [23:0] cw);
    int n;
    axw(REG_CTRL, m | 32'h2);
    axr(REG_STAT);
    chk(rd, 32'h2);
    n = 0;
    do begin
      axr(REG_STAT);
      n++;
    end while (rd[STAT_DONE] !== 1'b1 && n < 2000);
    if (n == 2000) tmo();
    for (int i = 0; i < NCH; i++) begin
      axr(REG_DATA0 + ADDR_W'(REG_STRIDE * i));
      chk(rd, ew(i, cw[3*i +: 3]));
    end
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(REG_CFG);
    chk(rd, 32'hffffff);
    axr(REG_STAT);
    chk(rd, 32'h0);
    axr(8'h40);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    axw(REG_CFG, 32'hfac688);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    conv(32'h0, 16'h1234, 1'b1);
    xfer(32'h0, 24'hffffff);
    conv(32'h0, 16'h8001, 1'b1);
    xfer(32'h0, 24'hfac688);
    axw(REG_CFG, 32'h053977);
    conv(32'h8, 16'h7ffe, 1'b1);
    xfer(32'h8, 24'hfac688);
    conv(32'h8, 16'h0f0f, 1'b1);
    xfer(32'h8, 24'h053977);
    // power-down blocks the start, then a second rise resets the config
    conv(32'h4, 16'h5555, 1'b0);
    axw(REG_CTRL, 32'h0);
    axw(REG_CTRL, 32'h4);
    axw(REG_CTRL, 32'h0);
    conv(32'h0, 16'haaaa, 1'b1);
    xfer(32'h0, 24'hffffff);
    print_verdict();
  end
endmodule // testbench
